/* File: inc/fault_status_two_pkg.sv */
// Package: offsets, field positions and types of the fault status two register
package fault_status_two_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] FAULT_STATUS_TWO_OFS = 8'h06;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h40;
   localparam logic [DATA_W-1:0] FAULT_STATUS_TWO_RST = 16'h0000;
   localparam logic [DATA_W-1:0] IRQ_MASK_RST = 16'h0000;
   localparam int USER_BIT = 15;
   localparam int MUX_BIT = 14;
   localparam int AUXSUM_BIT = 13;
   localparam int TEMP_BIT = 12;
   localparam int SCANTO_BIT = 11;
   localparam int ZS_BIT = 3;
   localparam int FS_BIT = 2;
   localparam int OV_BIT = 1;
   localparam int UV_BIT = 0;
   localparam logic [DATA_W-1:0] IMPL_MASK = 16'hF80F;
   localparam logic [1:0] BAL_CODE_THERMAL = 2'h3;
   localparam logic [2:0] SCAN_CFG_A = 3'h1;
   localparam logic [2:0] SCAN_CFG_B = 3'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic die_over_115c;
      logic supply_input_mux_fault;
      logic zero_scale_fail;
      logic full_scale_fail;
      logic acq_done;
      logic comp_ov_fail;
      logic comp_uv_fail;
      logic eos_done;
   } fault_events_s;
endpackage

/* File: design/fault_status_two_reg.sv */
// Fault status two register bank with alert forwarding and interrupt
// Function
// - 16-bit register at 0x06; alerts bits 15-11, reserved 10-4, results 3-0.
// - User test alert set by writing one, cleared by writing zero, resets zero.
// - User test alert drives the o_user_alert_active output.
// - Supply mux fault sets only with flex pack enabled and reset alert cleared.
// - Write zero clears mux fault only when resolved; write one ignored.
// - Aux summary is OR of enabled aux alerts on analog-configured pins.
// - Aux summary is read-only, clears with the aux alert register.
// - Over-temperature alert sets above 115C; write zero clears only once cool, one ignored.
// - Over-temperature during balancing, while its alert is still clear, ends it, code 11, thermal-stop alert.
// - Scan timeout alert mirrors scan timeout flag of scan control register.
// - Scan timeout alert active only while scan timeout disable is zero.
// - Low four flags reset zero, readable, cleared by writing zero.
// - Self-test flags set on failure only while self-test enable active.
// - Comparator flags set on failure with scan config 001/010 and enable.
`timescale 1ns/1ps
module fault_status_two_reg
   import fault_status_two_pkg::*;
#(
   parameter int AUX_N = 6
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire fault_status_two_pkg::reg_req_s i_req,
   output logic [fault_status_two_pkg::DATA_W-1:0] o_rdata,
   input wire fault_status_two_pkg::fault_events_s i_evt,
   input wire logic i_flex_pack_enable,
   input wire logic i_reset_occurred_alert,
   input wire logic [AUX_N-1:0] i_aux_protect_alert_bits,
   input wire logic [AUX_N-1:0] i_aux_analog_input,
   input wire logic i_scan_timeout_flag,
   input wire logic i_scan_timeout_disable,
   input wire logic i_converter_selftest_enable,
   input wire logic [2:0] i_scan_configuration,
   input wire logic i_comparator_accuracy_enable,
   input wire logic i_balancing_active,
   output logic o_balancing_stop,
   output logic [1:0] o_balancing_activity_code,
   output logic o_balancing_thermal_stop_alert,
   output logic o_user_alert_active,
   output logic o_irq
);
   import fault_status_two_pkg::*;

   // ==========================================
   // Input synchronisers
   logic [1:0] temp_sync;
   logic [1:0] mux_sync;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         temp_sync <= 2'h0;
      end else begin
         temp_sync <= {temp_sync[0], i_evt.die_over_115c};
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         mux_sync <= 2'h0;
      end else begin
         mux_sync <= {mux_sync[0], i_evt.supply_input_mux_fault};
      end
   end
   wire temp_hot = temp_sync[1];
   wire mux_fault = mux_sync[1];

   // ==========================================
   // Decode
   wire sel_fs = (i_req.addr == FAULT_STATUS_TWO_OFS);
   wire sel_mask = (i_req.addr == IRQ_MASK_OFS);
   wire wr_fs = i_req.wr && sel_fs;
   wire wr_mask = i_req.wr && sel_mask;
   wire rd_fs = i_req.rd && sel_fs;
   wire [DATA_W-1:0] wd = i_req.wdata;

   // ==========================================
   // Flags
   logic user_alert, mux_alert, temp_alert;
   wire [3:0] low_alert;
   logic [DATA_W-1:0] irq_mask;
   logic [DATA_W-1:0] irq_stat;
   logic bal_stop, bal_tsa;
   logic [1:0] bal_code;

   wire mux_arm = i_flex_pack_enable && !i_reset_occurred_alert;
   wire mux_set = mux_arm && mux_fault;
   wire mux_clr = wr_fs && !wd[MUX_BIT] && !mux_fault;
   wire next_mux = !mux_arm ? 1'b0 : (mux_set ? 1'b1 : (mux_clr ? 1'b0 : mux_alert));
   wire temp_clr = wr_fs && !wd[TEMP_BIT];
   wire next_temp = temp_hot ? 1'b1 : (temp_clr ? 1'b0 : temp_alert);
   wire zs_set = i_evt.acq_done && i_converter_selftest_enable && i_evt.zero_scale_fail;
   wire fs_set = i_evt.acq_done && i_converter_selftest_enable && i_evt.full_scale_fail;
   wire cmp_en = i_comparator_accuracy_enable &&
                 ((i_scan_configuration == SCAN_CFG_A) || (i_scan_configuration == SCAN_CFG_B));
   wire ov_set = i_evt.eos_done && cmp_en && i_evt.comp_ov_fail;
   wire uv_set = i_evt.eos_done && cmp_en && i_evt.comp_uv_fail;
   wire [3:0] low_set = {zs_set, fs_set, ov_set, uv_set};
   wire [3:0] low_clr = ~wd[3:0] & {4{wr_fs}};
   wire zs_alert = low_alert[ZS_BIT];
   wire fs_alert = low_alert[FS_BIT];
   wire ov_alert = low_alert[OV_BIT];
   wire uv_alert = low_alert[UV_BIT];
   wire next_user = wr_fs ? wd[USER_BIT] : user_alert;

   // ==========================================
   // Diagnostic result flags, one per bit
   for (genvar b = 0; b < 4; b++) begin : g_low
      logic flag;
      wire next_flag = low_set[b] | (flag & !low_clr[b]);
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
         if (!i_rstn) begin
            flag <= 1'b0;
         end else begin
            flag <= next_flag;
         end
      end
      assign low_alert[b] = flag;
   end

   wire aux_sum = |(i_aux_protect_alert_bits & i_aux_analog_input);
   wire scan_to = i_scan_timeout_flag && !i_scan_timeout_disable;

   wire [DATA_W-1:0] fs_value;
   assign fs_value = {user_alert, mux_alert, aux_sum, temp_alert, scan_to,
                      7'h00, zs_alert, fs_alert, ov_alert, uv_alert};

   wire thermal_hit = temp_hot && !temp_alert && i_balancing_active;

   // ==========================================
   // Interrupt events: rising flags latch sticky status
   logic [DATA_W-1:0] fs_prev;
   wire [DATA_W-1:0] rise = fs_value & ~fs_prev & IMPL_MASK;
   wire [DATA_W-1:0] next_stat = rise | (rd_fs ? 16'h0000 : irq_stat);
   wire [DATA_W-1:0] next_mask = wr_mask ? (wd & IMPL_MASK) : irq_mask;
   wire [DATA_W-1:0] rd_value = sel_fs ? fs_value : (sel_mask ? irq_mask : 16'h0000);
   wire [DATA_W-1:0] next_rdata = i_req.rd ? rd_value : 16'h0000;

   // ==========================================
   // Alert flags
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         user_alert <= 1'b0;
         mux_alert <= 1'b0;
         temp_alert <= 1'b0;
      end else begin
         user_alert <= next_user;
         mux_alert <= next_mux;
         temp_alert <= next_temp;
      end
   end

   // ==========================================
   // Interrupt status and mask
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_mask <= IRQ_MASK_RST;
         irq_stat <= FAULT_STATUS_TWO_RST;
         fs_prev <= FAULT_STATUS_TWO_RST;
      end else begin
         irq_mask <= next_mask;
         irq_stat <= next_stat;
         fs_prev <= fs_value;
      end
   end

   // ==========================================
   // Read data, zero outside the answer cycle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // ==========================================
   // Balancing termination on thermal alert
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         bal_stop <= 1'b0;
         bal_code <= 2'h0;
         bal_tsa <= 1'b0;
      end else begin
         bal_stop <= thermal_hit;
         bal_code <= thermal_hit ? BAL_CODE_THERMAL : bal_code;
         bal_tsa <= thermal_hit | bal_tsa;
      end
   end

   assign o_balancing_stop = bal_stop;
   assign o_balancing_activity_code = bal_code;
   assign o_balancing_thermal_stop_alert = bal_tsa;
   assign o_user_alert_active = user_alert;
   assign o_irq = |(irq_stat & irq_mask);

   // ==========================================
   // Assertions
   user_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      wr_fs |=> (user_alert == $past(wd[USER_BIT])))
      else $error("user alert does not follow write");
   user_fwd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_fs && wd[USER_BIT]) |=> o_user_alert_active)
      else $error("user alert not forwarded");
   user_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_fs && !wd[USER_BIT]) |=> !o_user_alert_active)
      else $error("user alert not cleared by write zero");
   user_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !wr_fs |=> $stable(user_alert))
      else $error("user alert changed without write");
   mux_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !mux_arm |=> !mux_alert)
      else $error("mux fault set while not armed");
   mux_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      mux_set |=> mux_alert)
      else $error("armed mux fault not latched");
   mux_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (mux_alert && mux_fault && mux_arm) |=> mux_alert)
      else $error("unresolved mux fault cleared");
   mux_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (mux_arm && wr_fs && !wd[MUX_BIT] && !mux_fault) |=> !mux_alert)
      else $error("resolved mux fault not cleared");
   mux_one_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (mux_alert && mux_arm && !(wr_fs && !wd[MUX_BIT])) |=> mux_alert)
      else $error("mux fault cleared without write zero");
   temp_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      temp_hot |=> temp_alert)
      else $error("over-temperature not latched");
   temp_one_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (temp_alert && wr_fs && wd[TEMP_BIT]) |=> temp_alert)
      else $error("write one cleared over-temperature");
   temp_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_fs && !wd[TEMP_BIT] && !temp_hot) |=> !temp_alert)
      else $error("over-temperature not cleared by write zero");
   temp_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!temp_alert && !temp_hot) |=> !temp_alert)
      else $error("over-temperature set while cool");
   thermal_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      thermal_hit |=> (o_balancing_stop && o_balancing_activity_code == 2'h3))
      else $error("balancing not ended on thermal alert");
   thermal_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      thermal_hit |=> o_balancing_thermal_stop_alert)
      else $error("thermal stop alert not set");
   stop_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_balancing_stop |=> !o_balancing_stop)
      else $error("balancing stop longer than one cycle");
   stop_cause_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !thermal_hit |=> !o_balancing_stop)
      else $error("balancing stop without thermal alert");
   scan_mirror_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      fs_value[SCANTO_BIT] == (i_scan_timeout_flag && !i_scan_timeout_disable))
      else $error("scan timeout mirror wrong");
   aux_sum_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      fs_value[AUXSUM_BIT] == |(i_aux_protect_alert_bits & i_aux_analog_input))
      else $error("aux summary wrong");

   // ==========================================
   // Assertions: diagnostic flags
   low_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_fs && !wd[ZS_BIT] && !zs_set) |=> !zs_alert)
      else $error("zero-scale flag not cleared");
   uv_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wr_fs && !wd[UV_BIT] && !uv_set) |=> !uv_alert)
      else $error("undervoltage flag not cleared");
   low_keep_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (ov_alert && !(wr_fs && !wd[OV_BIT])) |=> ov_alert)
      else $error("overvoltage flag lost without write zero");
   selftest_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!i_converter_selftest_enable && !zs_alert) |=> !zs_alert)
      else $error("self-test flag set while disabled");
   fs_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!i_converter_selftest_enable && !fs_alert) |=> !fs_alert)
      else $error("full-scale flag set while disabled");
   selftest_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      zs_set |=> zs_alert)
      else $error("zero-scale failure not latched");
   full_scale_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      fs_set |=> fs_alert)
      else $error("full-scale failure not latched");
   comp_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!cmp_en && !ov_alert) |=> !ov_alert)
      else $error("comparator flag set while disabled");
   uv_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!cmp_en && !uv_alert) |=> !uv_alert)
      else $error("undervoltage flag set while disabled");
   comp_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      ov_set |=> ov_alert)
      else $error("overvoltage failure not latched");
   uv_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      uv_set |=> uv_alert)
      else $error("undervoltage failure not latched");

   // ==========================================
   // Assertions: bus and interrupt
   reserved_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $past(rd_fs) |-> (o_rdata[10:4] == 7'h00))
      else $error("reserved bits not zero");
   read_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      rd_fs |=> (o_rdata == $past(fs_value)))
      else $error("read data differs from status");
   read_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !i_req.rd |=> (o_rdata == 16'h0000))
      else $error("read data not zero outside answer");
   mask_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      wr_mask |=> (irq_mask == ($past(wd) & IMPL_MASK)))
      else $error("mask write lost");
   irq_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (rd_fs && (rise == 16'h0000)) |=> (irq_stat == 16'h0000))
      else $error("status read did not clear events");
   irq_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (rise != 16'h0000) |=> ((irq_stat & $past(rise)) == $past(rise)))
      else $error("rising flag not latched as event");
endmodule

/* File: sim/fault_status_two_reg_bench.sv */
// Self-checking bench for the fault status two register bank
`timescale 1ns/1ps
module fault_status_two_reg_bench;
   import fault_status_two_pkg::*;
   // ======================================
   // Setup
   localparam logic [7:0] stat = FAULT_STATUS_TWO_OFS;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   reg_req_s req = '0;
   fault_events_s evt = '0;
   logic flex = 1'b0, rsta = 1'b0, sto = 1'b0, stod = 1'b0, zsen = 1'b0, cen = 1'b0, bal = 1'b0;
   logic [5:0] aux = 6'h00, ana = 6'h00;
   logic [2:0] cfg = 3'h0;
   logic [15:0] rdata;
   logic [1:0] bcode;
   logic bstop, btherm, uact, irq;
   int n_mismatch = 0;
   int compares = 0;
   fault_status_two_reg uut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
      .i_evt(evt), .i_flex_pack_enable(flex), .i_reset_occurred_alert(rsta),
      .i_aux_protect_alert_bits(aux), .i_aux_analog_input(ana), .i_scan_timeout_flag(sto),
      .i_scan_timeout_disable(stod), .i_converter_selftest_enable(zsen),
      .i_scan_configuration(cfg), .i_comparator_accuracy_enable(cen), .i_balancing_active(bal),
      .o_balancing_stop(bstop), .o_balancing_activity_code(bcode),
      .o_balancing_thermal_stop_alert(btherm), .o_user_alert_active(uact), .o_irq(irq));
   initial forever #2 i_clk_sys = ~i_clk_sys;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [15:0] exp);
      @(posedge i_clk_sys);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge i_clk_sys);
      req.rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ======================================
   // Scenarios
   task automatic t_reset();
      rd("status rst", stat, FAULT_STATUS_TWO_RST);
      rd("mask rst", IRQ_MASK_OFS, IRQ_MASK_RST);
      wr(8'h20, 16'hFFFF);
      rd("unmapped", 8'h20, 16'h0000);
   endtask
   task automatic t_user();
      wr(stat, 16'hFFFF);
      rd("user set", stat, 16'h8000);
      chk("user out", 16'h0001, {15'h0000, uact});
      wr(stat, 16'h0000);
      rd("user clr", stat, 16'h0000);
   endtask
   task automatic t_mux();
      cyc(1);
      evt.supply_input_mux_fault <= 1'b1;
      cyc(4);
      rd("mux no flex", stat, 16'h0000);
      cyc(1);
      flex <= 1'b1;
      rsta <= 1'b1;
      cyc(4);
      rd("mux rst alert", stat, 16'h0000);
      cyc(1);
      rsta <= 1'b0;
      cyc(4);
      rd("mux set", stat, 16'h4000);
      wr(stat, 16'h0000);
      rd("mux held", stat, 16'h4000);
      cyc(1);
      evt.supply_input_mux_fault <= 1'b0;
      cyc(4);
      rd("mux latched", stat, 16'h4000);
      wr(stat, 16'h4000);
      rd("mux w1", stat, 16'h4000);
      wr(stat, 16'h0000);
      rd("mux clr", stat, 16'h0000);
   endtask
   task automatic t_aux();
      cyc(1);
      aux <= 6'h20;
      ana <= 6'h1F;
      cyc(2);
      rd("aux off pin", stat, 16'h0000);
      cyc(1);
      ana <= 6'h20;
      cyc(2);
      rd("aux sum", stat, 16'h2000);
      wr(stat, 16'h0000);
      rd("aux ro", stat, 16'h2000);
      cyc(1);
      aux <= 6'h00;
      cyc(2);
      rd("aux clr", stat, 16'h0000);
   endtask
   task automatic t_temp();
      int pulses = 0;
      cyc(1);
      bal <= 1'b1;
      evt.die_over_115c <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         #1;
         if (bstop === 1'b1) begin
            pulses++;
         end
      end
      chk("bal stop", 16'h0001, 16'(pulses));
      rd("temp set", stat, 16'h1000);
      chk("bal code", 16'h0003, {14'h0000, bcode});
      chk("bal alert", 16'h0001, {15'h0000, btherm});
      cyc(1);
      evt.die_over_115c <= 1'b0;
      bal <= 1'b0;
      cyc(4);
      wr(stat, 16'h1000);
      rd("temp w1", stat, 16'h1000);
      wr(stat, 16'h0000);
      rd("temp clr", stat, 16'h0000);
   endtask
   task automatic t_scan();
      cyc(1);
      sto <= 1'b1;
      rd("scan to", stat, 16'h0800);
      wr(stat, 16'h0000);
      rd("scan held", stat, 16'h0800);
      cyc(1);
      stod <= 1'b1;
      rd("scan dis", stat, 16'h0000);
      cyc(1);
      stod <= 1'b0;
      rd("scan back", stat, 16'h0800);
      cyc(1);
      sto <= 1'b0;
      rd("scan clr", stat, 16'h0000);
   endtask
   task automatic t_low();
      for (int e = 0; e < 2; e++) begin
         cyc(1);
         zsen <= e[0];
         evt.zero_scale_fail <= 1'b1;
         evt.full_scale_fail <= 1'b1;
         evt.acq_done <= 1'b1;
         cyc(1);
         evt.acq_done <= 1'b0;
         cyc(2);
         rd("selftest", stat, e[0] ? 16'h000C : 16'h0000);
      end
      wr(stat, 16'h000F);
      rd("low w1", stat, 16'h000C);
      wr(stat, 16'h0000);
      rd("low clr", stat, 16'h0000);
      for (int c = 0; c < 5; c++) begin
         cyc(1);
         cfg <= (c == 4) ? 3'h1 : 3'(c);
         cen <= (c != 4);
         evt.comp_ov_fail <= 1'b1;
         evt.comp_uv_fail <= 1'b1;
         evt.eos_done <= 1'b1;
         cyc(1);
         evt.eos_done <= 1'b0;
         cyc(2);
         rd("comp", stat, (c == 1 || c == 2) ? 16'h0003 : 16'h0000);
         wr(stat, 16'h0000);
      end
   endtask
   task automatic t_irq();
      rd("pre irq", stat, 16'h0000);
      wr(stat, 16'h8000);
      #1;
      chk("irq masked", 16'h0000, {15'h0000, irq});
      wr(IRQ_MASK_OFS, 16'h8000);
      #1;
      chk("irq on", 16'h0001, {15'h0000, irq});
      rd("mask rd", IRQ_MASK_OFS, 16'h8000);
      rd("irq src", stat, 16'h8000);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      wr(stat, 16'h0000);
   endtask
   initial begin
      cyc(2);
      i_rstn <= 1'b1;
      t_reset();
      t_user();
      t_mux();
      t_aux();
      t_temp();
      t_scan();
      t_low();
      t_irq();
      report_and_stop();
   end
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
